// file: rtl/stnp_params.svh
`ifndef STNP_PARAMS_SVH
`define STNP_PARAMS_SVH

`define STNP_CLK_HZ      200000000
`define STNP_MS_CYC      (`STNP_CLK_HZ / 1000)
`define STNP_MIN_MS      60000
`define STNP_KA_MS       30000
`define STNP_BUF_BYTES   1024

`define STNP_A_DELIM     12'h000
`define STNP_A_FLUSH     12'h004
`define STNP_A_INACT     12'h008
`define STNP_A_NETIDLE   12'h00c
`define STNP_A_SESS      12'h010
`define STNP_A_SERIAL    12'h014
`define STNP_A_BAUD      12'h018
`define STNP_A_STATUS    12'h01c

`define STNP_F_DELIM2    8
`define STNP_F_STOP      2
`define STNP_F_PAR       3
`define STNP_F_FLOW      6
`define STNP_F_FIFO      8
`define STNP_F_SESS      16
`define STNP_F_DRAIN     20

`define STNP_DEF_NET_MIN 7'h07
`define STNP_MAX_NET_MIN 7'h63
`define STNP_DEF_SESS    3'h1
`define STNP_MAX_SESS    3'h4
`define STNP_DEF_SERIAL  9'h143

`define STNP_BAUD_DEF    115200
`define STNP_BAUD_V1_MIN 50
`define STNP_BAUD_V1_MAX 115200
`define STNP_BAUD_V2_MIN 110
`define STNP_BAUD_V2_MAX 230400
`define STNP_DIV(b)      (`STNP_CLK_HZ / (b))

`endif

// file: rtl/stnp_pkg.sv
package stnp_pkg;
   typedef enum logic {ST_FILL, ST_DRAIN} stnp_state_t;
   typedef enum logic [1:0] {STOP_1, STOP_1P5, STOP_2} stnp_stop_t;
   typedef enum logic [2:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_SPACE, PAR_MARK} stnp_parity_t;
   typedef enum logic [1:0] {FLOW_NONE, FLOW_RTS_CTS, FLOW_DTR_DSR, FLOW_XON_XOFF} stnp_flow_t;
endpackage

// file: rtl/stnp_timer.sv
`timescale 1ns/1ps
module stnp_timer
   import stnp_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   input  wire logic         tick,
   input  wire logic         restart,
   input  wire logic [W-1:0] limit,
   output logic             expired
);
   logic [W-1:0] count;

   // a zero limit holds the timer off
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count   <= '0;
         expired <= 1'b0;
      end else if (clk_en) begin
         if (restart || limit == '0) begin
            count   <= '0;
            expired <= 1'b0;
         end else if (tick && !expired) begin
            count <= count + W'(1);
            if (count == limit - W'(1)) begin
               expired <= 1'b1;
            end
         end
      end
   end

   restart_clears_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && restart |=> !expired) else $error("timer not cleared by restart");
endmodule

// file: rtl/stnp_packer.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "stnp_params.svh"
// Notes on behaviour
// - no delimiter: forward each byte at once
// - delimiter set: hold bytes until it arrives
// - second delimiter nonzero means two-character match
// - both delimiters zero disables matching
// - full one-kilobyte buffer is sent and emptied
// - idle gap after last byte flushes buffer
// - idle flush in ms, zero disables
// - serial inactivity closes sessions, zero disables
// - network idle minutes close session, default seven
// - unanswered periodic probe forces session closed
// - session limit one to four, default one
// - frames go to every open session
// - network bytes reach serial in order
// - 5-8 data bits; 5 bits forces 1.5 stop
// - both serial fifos can be switched off
// - baud divisor limited to board range
module stnp_packer
   import stnp_pkg::*;
#(
   parameter int BUF_BYTES = `STNP_BUF_BYTES,
   parameter int MS_CYC    = `STNP_MS_CYC,
   parameter int MIN_MS    = `STNP_MIN_MS,
   parameter int KA_MS     = `STNP_KA_MS,
   parameter bit BOARD_V2  = 1'b0
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   output logic             rx_ready,
   output logic             frame_valid,
   output logic [7:0]       frame_data,
   output logic             frame_last,
   output logic [3:0]       frame_dest,
   input  wire logic        frame_ready,
   input  wire logic        net_valid,
   input  wire logic [7:0]  net_data,
   output logic             net_ready,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   input  wire logic        tx_ready,
   input  wire logic [3:0]  host_open_req,
   input  wire logic [3:0]  host_close_req,
   input  wire logic [3:0]  net_act,
   input  wire logic [3:0]  probe_ack,
   output logic [3:0]       sess_open,
   output logic [3:0]       sess_drop,
   output logic [3:0]       probe,
   output logic [1:0]       ser_bits,
   output stnp_stop_t       ser_stop,
   output stnp_parity_t     ser_parity,
   output stnp_flow_t       ser_flow,
   output logic             ser_fifo_en,
   output logic [21:0]      baud_div
);
   localparam int AW = $clog2(BUF_BYTES);
   localparam logic [21:0] DIV_LO = 22'(BOARD_V2 ? `STNP_DIV(`STNP_BAUD_V2_MAX)
                                                 : `STNP_DIV(`STNP_BAUD_V1_MAX));
   localparam logic [21:0] DIV_HI = 22'(BOARD_V2 ? `STNP_DIV(`STNP_BAUD_V2_MIN)
                                                 : `STNP_DIV(`STNP_BAUD_V1_MIN));

   stnp_state_t  state;
   logic [7:0]   delim1;
   logic [7:0]   delim2;
   logic [15:0]  flush_ms;
   logic [15:0]  inact_ms;
   logic [6:0]   net_min;
   logic [2:0]   max_sess;
   logic         stop_two;
   logic [7:0]   buf_mem [BUF_BYTES];
   logic [AW:0]  cnt;
   logic [AW-1:0] rd;
   logic [7:0]   prev_byte;
   logic         prev_ok;
   logic [17:0]  ms_cnt;
   logic         ms_tick;
   logic         min_tick;
   logic         ka_tick;
   logic         flush_exp;
   logic         inact_exp;
   logic [6:0]   idle_min [4];
   logic [3:0]   probe_pend;
   logic [3:0]   next_open;
   logic [3:0]   next_drop;
   logic [31:0]  rdata;
   logic [2:0]   open_n;
   logic         rx_acc;
   logic         tx_acc;
   logic         net_acc;
   logic         delim_on;
   logic         delim_hit;
   logic         wr_hit;

   function automatic logic [2:0] popcnt(input logic [3:0] m);
      popcnt = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= `STNP_A_STATUS);
   endfunction

   assign rx_acc    = rx_valid && rx_ready;
   assign tx_acc    = tx_valid && tx_ready;
   assign net_acc   = net_valid && net_ready;
   assign open_n    = popcnt(sess_open);
   assign delim_on  = (delim1 != 8'h00) || (delim2 != 8'h00);
   // a pair needs its first half already inside this buffer
   assign delim_hit = (delim2 == 8'h00) ? (rx_data == delim1)
                      : (prev_ok && prev_byte == delim1 && rx_data == delim2);
   assign wr_hit    = psel && penable && pready && pwrite && mapped(paddr);

   // zero wait state slave answering in the first access cycle
   always_comb begin
      rdata = 32'h0;
      case (paddr)
         `STNP_A_DELIM:   rdata = {16'h0, delim2, delim1};
         `STNP_A_FLUSH:   rdata = {16'h0, flush_ms};
         `STNP_A_INACT:   rdata = {16'h0, inact_ms};
         `STNP_A_NETIDLE: rdata = {25'h0, net_min};
         `STNP_A_SESS:    rdata = {29'h0, max_sess};
         `STNP_A_SERIAL:  rdata = {23'h0, ser_fifo_en, ser_flow, ser_parity, stop_two, ser_bits};
         `STNP_A_BAUD:    rdata = {10'h0, baud_div};
         `STNP_A_STATUS:  rdata = {11'h0, state == ST_DRAIN, sess_open, 5'h0, 11'(cnt)};
         default:         rdata = 32'h0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= psel && !penable;
         prdata  <= rdata;
         pslverr <= psel && !penable && !mapped(paddr);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         delim1      <= 8'h00;
         delim2      <= 8'h00;
         flush_ms    <= 16'h0000;
         inact_ms    <= 16'h0000;
         net_min     <= `STNP_DEF_NET_MIN;
         max_sess    <= `STNP_DEF_SESS;
         ser_bits    <= 2'(`STNP_DEF_SERIAL);
         stop_two    <= 1'b0;
         ser_parity  <= PAR_NONE;
         ser_flow    <= FLOW_RTS_CTS;
         ser_fifo_en <= 1'b1;
         baud_div    <= 22'(`STNP_DIV(`STNP_BAUD_DEF));
      end else if (clk_en && wr_hit) begin
         case (paddr)
            `STNP_A_DELIM: begin
               delim1 <= pwdata[7:0];
               delim2 <= pwdata[`STNP_F_DELIM2 +: 8];
            end
            `STNP_A_FLUSH:   flush_ms <= pwdata[15:0];
            `STNP_A_INACT:   inact_ms <= pwdata[15:0];
            `STNP_A_NETIDLE: begin
               net_min <= (pwdata[6:0] > `STNP_MAX_NET_MIN || pwdata[31:7] != 25'h0)
                          ? `STNP_MAX_NET_MIN : pwdata[6:0];
            end
            `STNP_A_SESS: begin
               if (pwdata[2:0] == 3'h0) begin
                  max_sess <= 3'h1;
               end else begin
                  max_sess <= (pwdata[2:0] > `STNP_MAX_SESS) ? `STNP_MAX_SESS
                              : pwdata[2:0];
               end
            end
            `STNP_A_SERIAL: begin
               ser_bits    <= pwdata[1:0];
               stop_two    <= pwdata[`STNP_F_STOP];
               ser_parity  <= (pwdata[`STNP_F_PAR +: 3] > 3'h4) ? PAR_NONE
                              : stnp_parity_t'(pwdata[`STNP_F_PAR +: 3]);
               ser_flow    <= stnp_flow_t'(pwdata[`STNP_F_FLOW +: 2]);
               ser_fifo_en <= pwdata[`STNP_F_FIFO];
            end
            `STNP_A_BAUD: begin
               // out-of-range rates are pulled to the nearest supported one
               if (pwdata[31:22] != 10'h0 || pwdata[21:0] > DIV_HI) begin
                  baud_div <= DIV_HI;
               end else if (pwdata[21:0] < DIV_LO) begin
                  baud_div <= DIV_LO;
               end else begin
                  baud_div <= pwdata[21:0];
               end
            end
            default: ;
         endcase
      end
   end

   // five-bit characters always get one and a half stop bits
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ser_stop <= STOP_1;
      end else if (clk_en) begin
         ser_stop <= (ser_bits == 2'h0) ? STOP_1P5 : (stop_two ? STOP_2 : STOP_1);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ms_cnt  <= 18'h00000;
         ms_tick <= 1'b0;
      end else if (clk_en) begin
         ms_tick <= (ms_cnt == 18'(MS_CYC - 1));
         ms_cnt  <= (ms_cnt == 18'(MS_CYC - 1)) ? 18'h00000 : ms_cnt + 18'h00001;
      end
   end

   stnp_timer #(.W(16)) u_min (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .tick(ms_tick),
      .restart(min_tick), .limit(16'(MIN_MS)), .expired(min_tick));

   stnp_timer #(.W(16)) u_ka (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .tick(ms_tick),
      .restart(ka_tick), .limit(16'(KA_MS)), .expired(ka_tick));

   stnp_timer #(.W(16)) u_flush (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .tick(ms_tick),
      .restart(rx_acc), .limit(flush_ms), .expired(flush_exp));

   // traffic either way on the serial side keeps sessions alive
   stnp_timer #(.W(16)) u_inact (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .tick(ms_tick),
      .restart(rx_acc || tx_acc || sess_open == 4'h0), .limit(inact_ms),
      .expired(inact_exp));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state       <= ST_FILL;
         cnt         <= '0;
         rd          <= '0;
         prev_byte   <= 8'h00;
         prev_ok     <= 1'b0;
         rx_ready    <= 1'b1;
         frame_valid <= 1'b0;
         frame_data  <= 8'h00;
         frame_last  <= 1'b0;
         frame_dest  <= 4'h0;
      end else if (clk_en) begin
         case (state)
            ST_FILL: begin
               if (rx_acc) begin
                  buf_mem[cnt[AW-1:0]] <= rx_data;
                  cnt       <= cnt + (AW+1)'(1);
                  prev_byte <= rx_data;
                  prev_ok   <= 1'b1;
                  if (!delim_on || delim_hit ||
                      cnt == (AW+1)'(BUF_BYTES - 1)) begin
                     state    <= ST_DRAIN;
                     rx_ready <= 1'b0;
                     rd       <= '0;
                  end
               end else if (flush_exp && cnt != '0) begin
                  state    <= ST_DRAIN;
                  rx_ready <= 1'b0;
                  rd       <= '0;
               end
            end
            ST_DRAIN: begin
               // one idle cycle per byte buys a registered read of the store
               if (!frame_valid) begin
                  frame_valid <= 1'b1;
                  frame_data  <= buf_mem[rd];
                  frame_last  <= ((AW+1)'(rd) == cnt - (AW+1)'(1));
                  frame_dest  <= sess_open;
               end else if (frame_ready) begin
                  frame_valid <= 1'b0;
                  if (frame_last) begin
                     state    <= ST_FILL;
                     cnt      <= '0;
                     prev_ok  <= 1'b0;
                     rx_ready <= 1'b1;
                  end else begin
                     rd <= rd + AW'(1);
                  end
               end
            end
            default: state <= ST_FILL;
         endcase
      end
   end

   // single stage keeps network bytes strictly in arrival order
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_valid  <= 1'b0;
         tx_data   <= 8'h00;
         net_ready <= 1'b1;
      end else if (clk_en) begin
         if (net_acc) begin
            tx_valid  <= 1'b1;
            tx_data   <= net_data;
            net_ready <= 1'b0;
         end else if (tx_acc) begin
            tx_valid  <= 1'b0;
            net_ready <= 1'b1;
         end
      end
   end

   always_comb begin
      next_open = sess_open & ~host_close_req;
      next_drop = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (sess_open[i] && ka_tick && probe_pend[i]) begin
            next_drop[i] = 1'b1;
         end
         if (sess_open[i] && net_min != 7'h00 && idle_min[i] >= net_min) begin
            next_drop[i] = 1'b1;
         end
      end
      if (inact_exp) begin
         next_drop = sess_open;
      end
      next_open = next_open & ~next_drop;
      for (int i = 0; i < 4; i++) begin
         if (host_open_req[i] && !next_open[i] && popcnt(next_open) < max_sess) begin
            next_open[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sess_open  <= 4'h0;
         sess_drop  <= 4'h0;
         probe      <= 4'h0;
         probe_pend <= 4'h0;
      end else if (clk_en) begin
         sess_open <= next_open;
         sess_drop <= next_drop;
         probe     <= ka_tick ? sess_open : 4'h0;
         for (int i = 0; i < 4; i++) begin
            if (!next_open[i]) begin
               probe_pend[i] <= 1'b0;
            end else if (ka_tick) begin
               probe_pend[i] <= 1'b1;
            end else if (probe_ack[i]) begin
               probe_pend[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            idle_min[i] <= 7'h00;
         end
      end else if (clk_en) begin
         for (int i = 0; i < 4; i++) begin
            if (!sess_open[i] || net_act[i]) begin
               idle_min[i] <= 7'h00;
            end else if (min_tick && idle_min[i] < `STNP_MAX_NET_MIN) begin
               idle_min[i] <= idle_min[i] + 7'h01;
            end
         end
      end
   end

   immediate_fwd_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state == ST_FILL && rx_acc && !delim_on
      |=> state == ST_DRAIN && cnt == $past(cnt) + 1'b1)
      else $error("byte not forwarded at once");
   delim_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state == ST_FILL && rx_acc && delim_on && !delim_hit && cnt < 100
      |=> state == ST_FILL) else $error("buffer flushed without delimiter");
   pair_delim_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state == ST_FILL && rx_acc && delim2 != 8'h00 && prev_ok
      && prev_byte == delim1 && rx_data == delim2 |=> state == ST_DRAIN)
      else $error("delimiter pair missed");
   full_flush_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state == ST_FILL && rx_acc && cnt == (AW+1)'(BUF_BYTES - 1)
      |=> state == ST_DRAIN && !rx_ready) else $error("full buffer not sent");
   idle_flush_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state == ST_FILL && !rx_acc && flush_exp && cnt != '0
      |=> state == ST_DRAIN) else $error("idle flush missed");
   inact_close_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && inact_exp |=> sess_open == 4'h0) else $error("inactive sessions kept");
   probe_close_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && ka_tick && sess_open[0] && probe_pend[0] |=> !sess_open[0] && sess_drop[0])
      else $error("unanswered probe kept session");
   sess_limit_a: assert property (@(posedge clock) disable iff (!rst_n)
      open_n > $past(open_n) |-> open_n <= max_sess) else $error("session limit exceeded");
   tx_order_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && net_acc |=> tx_valid && tx_data == $past(net_data) && !net_ready)
      else $error("network byte lost or reordered");
   stop_force_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && ser_bits == 2'h0 |=> ser_stop == STOP_1P5) else $error("stop bits not forced");

   delim_frame_c: cover property (@(posedge clock) disable iff (!rst_n)
      clk_en && rx_acc && delim_on && delim_hit);
   full_frame_c: cover property (@(posedge clock) disable iff (!rst_n)
      clk_en && rx_acc && cnt == (AW+1)'(BUF_BYTES - 1));
   probe_drop_c: cover property (@(posedge clock) disable iff (!rst_n)
      sess_drop != 4'h0);
endmodule

// file: tb/stnp_far_model.sv
`timescale 1ns/1ps
module stnp_far_model (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       ack_en,
   input  wire logic [3:0] probe,
   output logic            frame_ready,
   output logic            tx_ready,
   output logic [3:0]      probe_ack
);
   int seed = 32'h5721519a;
   // random stalls on both sides, so drains never see a kind partner
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         frame_ready <= 1'b0;
         tx_ready    <= 1'b0;
         probe_ack   <= 4'h0;
      end else begin
         frame_ready <= 1'($random(seed));
         tx_ready    <= 1'($random(seed) >>> 3);
         probe_ack   <= ack_en ? probe : 4'h0;
      end
   end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import stnp_pkg::*;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ack_en = 1, clk_en = 1;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, rx_valid = 0, rx_ready, frame_valid, frame_last, frame_ready;
   logic [7:0] rx_data = '0, frame_data, net_data = '0, tx_data;
   logic net_valid = 0, net_ready, tx_valid, tx_ready, ser_fifo_en;
   logic [3:0] frame_dest, host_open_req = '0, sess_open, probe, probe_ack;
   logic [3:0] host_close_req = '0, net_act = '0, sess_drop;
   logic [1:0] ser_bits;
   stnp_stop_t ser_stop;
   stnp_parity_t ser_parity;
   stnp_flow_t ser_flow;
   logic [21:0] baud_div;
   int mismatches = 0, num_checks = 0, seed = 32'h5721519a;
   logic [12:0] fq[$];
   logic [7:0] txq[$];
   stnp_packer #(.MS_CYC(10), .MIN_MS(3), .KA_MS(4)) stnp_packer_i (
      .clock, .rst_n, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .rx_valid, .rx_data, .rx_ready, .frame_valid, .frame_data,
      .frame_last, .frame_dest, .frame_ready, .net_valid, .net_data, .net_ready, .tx_valid,
      .tx_data, .tx_ready, .host_open_req, .host_close_req, .net_act,
      .probe_ack, .sess_open, .sess_drop, .probe, .ser_bits, .ser_stop, .ser_parity,
      .ser_flow, .ser_fifo_en, .baud_div);
   stnp_far_model stnp_far_model_i (.clock, .rst_n, .ack_en, .probe, .frame_ready,
      .tx_ready, .probe_ack);
   always #2.5 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk(32'(pready), 32'h1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // byte source holds each byte until the block takes it
   task automatic rx(input logic [7:0] b);
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data  <= b;
      do @(negedge clock); while (rx_ready !== 1'b1);
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_data  <= ~b;
   endtask
   task automatic net(input logic [7:0] b);
      @(posedge clock);
      net_valid <= 1'b1;
      net_data  <= b;
      do @(negedge clock); while (net_ready !== 1'b1);
      @(posedge clock);
      net_valid <= 1'b0;
      net_data  <= ~b;
   endtask
   function automatic logic [7:0] rb();
      logic [7:0] b = 8'($random(seed));
      return (b == 8'h0d || b == 8'h0a) ? 8'h55 : b;
   endfunction
   task automatic frame_of(input logic [7:0] s[$], input logic [3:0] d);
      for (int i = 0; i < s.size(); i++) begin
         fq.push_back({d, i == s.size() - 1, s[i]});
         rx(s[i]);
      end
   endtask
   task automatic drain(input string t);
      int n = 0;
      while ((fq.size() + txq.size()) > 0 && n < 6000) begin
         @(posedge clock);
         n++;
      end
      chk(32'(fq.size() + txq.size()), 32'h0);
      $display("test %s done", t);
   endtask
   task automatic open_s(input logic [3:0] m, input logic [3:0] c, input logic [3:0] x);
      @(posedge clock);
      host_open_req  <= m;
      host_close_req <= c;
      @(posedge clock);
      host_open_req  <= 4'h0;
      host_close_req <= 4'h0;
      repeat (2) @(negedge clock);
      chk(32'(sess_open), 32'(x));
   endtask
   task automatic closed_by(input int n, input logic [3:0] x);
      logic [3:0] seen = 4'h0;
      repeat (n) begin
         @(negedge clock);
         seen |= sess_drop;
      end
      chk(32'(sess_open), 32'h0);
      chk(32'(seen), 32'(x));
   endtask
   always @(posedge clock) begin
      if (rst_n && frame_valid === 1'b1 && frame_ready === 1'b1) begin
         if (fq.size() == 0) chk(32'h1, 32'h0);
         else chk({19'h0, frame_dest, frame_last, frame_data}, 32'(fq.pop_front()));
      end
      if (rst_n && tx_valid === 1'b1 && tx_ready === 1'b1) begin
         if (txq.size() == 0) chk(32'h1, 32'h0);
         else chk(32'(tx_data), 32'(txq.pop_front()));
      end
   end
   initial begin
      #250us;
      chk(32'h0, 32'h1);
      report_and_stop();
   end
   initial begin
      logic [7:0] big[$], b;
      logic [2:0] p;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      chk(32'({ser_fifo_en, ser_flow, ser_parity, ser_bits, ser_stop}), 32'h28c);
      chk(32'(baud_div), 200000000 / 115200);
      rd(12'h00c, 32'h7, 1'b0);
      rd(12'h010, 32'h1, 1'b0);
      rd(12'h020, 32'h0, 1'b1);
      wr(12'h000, 32'h0);
      for (int i = 0; i < 6; i++) frame_of({rb()}, 4'h0);
      drain("immediate");
      wr(12'h000, 32'h0d);
      frame_of({rb(), rb(), rb(), 8'h0d}, 4'h0);
      wr(12'h000, 32'h0a0d);
      frame_of({rb(), 8'h0d, rb(), 8'h0d, 8'h0a}, 4'h0);
      drain("delimiter");
      wr(12'h004, 32'h2);
      frame_of({rb(), rb(), rb()}, 4'h0);
      // frozen block must hold the flush past its interval
      clk_en <= 1'b0;
      repeat (40) @(negedge clock);
      chk(32'(frame_valid), 32'h0);
      @(posedge clock);
      clk_en <= 1'b1;
      drain("idle flush");
      wr(12'h004, 32'h0);
      b = rb();
      fq.push_back({4'h0, 1'b0, b});
      fq.push_back({4'h0, 1'b1, 8'h0d});
      rx(b);
      repeat (60) @(posedge clock); // zero interval must not flush
      rx(8'h0d);
      rx(8'h0a);
      fq.pop_back();
      fq.push_back({4'h0, 1'b0, 8'h0d});
      fq.push_back({4'h0, 1'b1, 8'h0a});
      drain("flush off");
      for (int i = 0; i < 1024; i++) big.push_back(rb());
      frame_of(big, 4'h0);
      drain("full buffer");
      for (int i = 0; i < 8; i++) begin
         wr(12'h014, {23'h0, i[0], i[1:0], i[2:0], 1'b1, 2'h3});
         p = (i > 4) ? 3'h0 : 3'(i);
         repeat (2) @(negedge clock);
         chk(32'({ser_fifo_en, ser_flow}), 32'({i[0], i[1:0]}));
         chk(32'({ser_parity, ser_stop}), 32'({p, 2'h2}));
      end
      wr(12'h014, 32'h4);
      repeat (2) @(negedge clock);
      chk(32'({ser_bits, ser_stop}), 32'h1);
      wr(12'h018, 32'd10);
      repeat (2) @(negedge clock);
      chk(32'(baud_div), 32'd1736);
      wr(12'h018, 32'h00400000);
      @(negedge clock);
      chk(32'(baud_div), 32'd4000000);
      for (int i = 0; i < 8; i++) begin
         b = rb();
         txq.push_back(b);
         net(b);
      end
      drain("net to serial");
      wr(12'h010, 32'h2);
      wr(12'h000, 32'h0);
      open_s(4'h7, 4'h0, 4'h3);
      rd(12'h01c, 32'h00030000, 1'b0);
      frame_of({rb()}, 4'h3);
      drain("sessions");
      open_s(4'h0, 4'h2, 4'h1);
      wr(12'h008, 32'h3); // inactivity above zero flush interval
      closed_by(80, 4'h1);
      wr(12'h008, 32'h0);
      wr(12'h00c, 32'h1);
      @(posedge clock);
      net_act <= 4'h1;
      open_s(4'h1, 4'h0, 4'h1);
      repeat (70) @(posedge clock);
      net_act <= 4'h0;
      @(negedge clock);
      chk(32'(sess_open), 32'h1);
      closed_by(70, 4'h1);
      wr(12'h00c, 32'h0);
      ack_en <= 1'b0;
      open_s(4'h1, 4'h0, 4'h1);
      closed_by(120, 4'h1);
      drain("closing");
      report_and_stop();
   end
endmodule
